// File: verilog/bsfc_top.v
`timescale 1ns/1ns
`include "bsfc_consts.vh"
module bsfc_top (
   input wire clk_i,
   input wire rst_i,
   input wire left_port_clock_i,
   input wire left_chip_select_n_i,
   input wire left_direction_i,
   input wire left_mail_select_i,
   input wire [35:0] left_data_i,
   output wire [35:0] left_data_o,
   output wire left_data_oe_o,
   input wire right_port_clock_i,
   input wire right_chip_select_n_i,
   input wire right_direction_i,
   input wire right_mail_select_i,
   input wire [35:0] right_data_i,
   output wire [35:0] right_data_o,
   output wire right_data_oe_o,
   input wire fwd_master_reset_n_i,
   input wire rev_master_reset_n_i,
   input wire fwd_replay_n_i,
   input wire rev_replay_n_i,
   input wire fall_through_select_i,
   input wire offset_program_select_i,
   output wire left_full_n_o,
   output wire left_input_ready_o,
   output wire right_full_n_o,
   output wire right_input_ready_o,
   output wire left_empty_n_o,
   output wire left_output_ready_o,
   output wire right_empty_n_o,
   output wire right_output_ready_o,
   output wire left_almost_empty_n_o,
   output wire right_almost_empty_n_o,
   output wire left_almost_full_n_o,
   output wire right_almost_full_n_o
);
   // ****************************************************
   // Constants
   // ****************************************************
   localparam DW = `BSFC_DW;
   localparam AW = `BSFC_AW;
   localparam PW = `BSFC_PW;
   // Recovery wait in clock cycles
   localparam integer RECOV_N = `BSFC_RECOV_CYC;
   localparam [2:0] RECOV = RECOV_N[2:0];
   // Full hold after replay: recovery plus near-flag wait
   localparam [2:0] HOLD_MAX = RECOV + `BSFC_NEAR_HOLD;

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   wire [39:0] l_s; // Left pins after filtering
   wire [39:0] r_s; // Right pins after filtering
   wire [5:0] m_s; // Reset, replay and mode pins

   // Left port: clock and select idle high at start
   bsfc_sync3 #(.W(40), .INIT(40'h0000000003)) u_sync_l (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({left_data_i, left_mail_select_i, left_direction_i,
                left_chip_select_n_i, left_port_clock_i}),
      .sync_o(l_s)
   );

   // Right port, same layout
   bsfc_sync3 #(.W(40), .INIT(40'h0000000003)) u_sync_r (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({right_data_i, right_mail_select_i, right_direction_i,
                right_chip_select_n_i, right_port_clock_i}),
      .sync_o(r_s)
   );

   // Control pins: resets start asserted, replay idle high
   bsfc_sync3 #(.W(6), .INIT(6'h0C)) u_sync_m (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({offset_program_select_i, fall_through_select_i,
                rev_replay_n_i, fwd_replay_n_i,
                rev_master_reset_n_i, fwd_master_reset_n_i}),
      .sync_o(m_s)
   );

   wire l_dir_s = l_s[2]; // Left direction
   wire r_dir_s = r_s[2]; // Right direction
   wire [DW-1:0] l_data_s = l_s[39:4]; // Left data in
   wire [DW-1:0] r_data_s = r_s[39:4]; // Right data in
   wire fall_through_select_s = m_s[4]; // Fall-through mode level
   wire load_sel_s = m_s[5]; // High selects parallel offsets

   // ****************************************************
   // Port clock edges and access decode
   // ****************************************************
   reg l_clk_prev_ff; // Left clock of last cycle
   reg r_clk_prev_ff; // Right clock of last cycle
   reg l_oe_ff; // Left bus drive
   reg r_oe_ff; // Right bus drive

   // Track port clock levels; drive bus when reading
   always @(posedge clk_i) begin
      if (rst_i) begin
         l_clk_prev_ff <= 1'h1;
         r_clk_prev_ff <= 1'h1;
         l_oe_ff <= 1'h0;
         r_oe_ff <= 1'h0;
      end else begin
         l_clk_prev_ff <= l_s[0];
         r_clk_prev_ff <= r_s[0];
         l_oe_ff <= ~l_s[1] & ~l_dir_s;
         r_oe_ff <= ~r_s[1] & r_dir_s;
      end
   end

   wire l_edge = l_s[0] & ~l_clk_prev_ff; // Left rising edge
   wire r_edge = r_s[0] & ~r_clk_prev_ff; // Right rising edge
   // FIFO access: select low and mail select low
   wire l_sel = ~l_s[1] & ~l_s[3];
   wire r_sel = ~r_s[1] & ~r_s[3];

   // Per FIFO views: index 0 forward, 1 reverse
   wire [1:0] wr_edge = {r_edge, l_edge};
   wire [1:0] rd_edge = {l_edge, r_edge};
   wire [1:0] wr_cmd;
   wire [1:0] rd_cmd;
   assign wr_cmd[0] = l_sel & l_dir_s; // R3
   assign rd_cmd[0] = r_sel & r_dir_s; // R4
   assign wr_cmd[1] = r_sel & ~r_dir_s; // R5
   assign rd_cmd[1] = l_sel & ~l_dir_s; // R6
   wire [2*DW-1:0] wr_data = {r_data_s, l_data_s};
   // Master resets, active high inside
   wire [1:0] mrst_act = ~m_s[1:0];
   // Replay requests, ignored in fall-through mode
   wire [1:0] replay_act = ~m_s[3:2] & {2{~fall_through_select_s}}; // R17 R21

   // Collected per FIFO state
   wire [1:0] space_w; // Memory not full
   wire [1:0] prog_w; // Offset programming pending
   wire [1:0] full_n_w;
   wire [1:0] iready_w;
   wire [1:0] empty_n_w;
   wire [1:0] oready_w;
   wire [1:0] ae_n_w;
   wire [1:0] af_n_w;
   wire [2*DW-1:0] out_w;
   wire prog_any = |prog_w;
   // Offset write from the left, only while forward has room
   wire prog_wr = l_edge & l_sel & l_dir_s & space_w[0]; // R1

   // ****************************************************
   // FIFO channels
   // ****************************************************
   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : g_ch
         reg [PW-1:0] wptr_ff; // Write pointer
         reg [PW-1:0] rptr_ff; // Read pointer
         reg [PW-1:0] wsync1_ff; // Write pointer, read side 1
         reg [PW-1:0] wsync2_ff; // Write pointer, read side 2
         reg [PW-1:0] rsync1_ff; // Read pointer, write side 1
         reg [PW-1:0] rsync2_ff; // Read pointer, write side 2
         reg [DW-1:0] out_ff; // Output register
         reg ov_ff; // Output register holds a word
         reg fetch_ff; // Memory read in flight
         reg space_ff; // Room in memory
         reg avail_ff; // Words in memory
         reg full_n_ff;
         reg iready_ff;
         reg empty_n_ff;
         reg oready_ff;
         reg ae_n_ff;
         reg af_n_ff;
         reg [2:0] hold_ff; // Replay recovery counter
         reg [AW-1:0] ne_ff; // Near-empty offset
         reg [AW-1:0] nf_ff; // Near-full offset
         reg prog_ff; // Waiting for offset words
         reg step_ff; // Next offset word is near-full
         reg mprev_ff; // Master reset of last cycle
         wire [DW-1:0] mem_q;

         // Forward waits for nothing; reverse waits for forward
         wire turn = (c == 0) ? 1'h1 : ~prog_w[0];
         // Memory words seen from each side
         wire [PW-1:0] rcount = wsync2_ff - rptr_ff;
         wire [PW-1:0] wcount = wptr_ff - rsync2_ff;
         // Near-full sum, one bit wider
         wire [PW:0] nf_sum = {1'h0, wcount} + {2'h0, nf_ff};
         // Accepted write; left writes blocked while programming
         wire wr_ok = wr_edge[c] & wr_cmd[c] & space_ff &
                      ~mrst_act[c] & ((c == 0) ? ~prog_any : 1'h1);
         // Read taken: from register in fall-through mode
         wire rd_take = rd_edge[c] & rd_cmd[c] & ~mrst_act[c] &
                        (fall_through_select_s ? ov_ff : avail_ff);
         // Memory fetch: on demand, or to refill empty register
         wire fetch = rd_edge[c] & ~mrst_act[c] & avail_ff &
                      ~replay_act[c] &
                      (fall_through_select_s ? (~ov_ff | rd_take) : rd_take); // R7 R8

         bsfc_mem #(.DW(DW), .AW(AW)) u_mem (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .wr_en_i(wr_ok),
            .wr_addr_i(wptr_ff[AW-1:0]),
            .wr_data_i(wr_data[c*DW +: DW]),
            .rd_addr_i(rptr_ff[AW-1:0]),
            .rd_data_o(mem_q)
         );

         // Offsets: preset at reset, then optional load
         always @(posedge clk_i) begin
            if (rst_i) begin
               ne_ff <= `BSFC_OFF_RST;
               nf_ff <= `BSFC_OFF_RST;
               prog_ff <= 1'h0;
               step_ff <= 1'h0;
               mprev_ff <= 1'h1;
            end else begin
               mprev_ff <= mrst_act[c];
               if (mrst_act[c]) begin
                  // Preset of eight on both offsets
                  ne_ff <= `BSFC_OFF_RST; // R22
                  nf_ff <= `BSFC_OFF_RST; // R22
                  prog_ff <= 1'h0;
                  step_ff <= 1'h0;
               end else if (mprev_ff) begin
                  // Reset release picks the load method
                  prog_ff <= load_sel_s;
               end else if (prog_wr & prog_ff & turn) begin
                  // Words may arrive any cycles apart
                  if (step_ff) begin // R2
                     nf_ff <= l_data_s[`BSFC_OFF_LSB +: AW]; // R24
                     prog_ff <= 1'h0;
                  end else begin
                     ne_ff <= l_data_s[`BSFC_OFF_LSB +: AW]; // R24
                  end
                  step_ff <= ~step_ff;
               end
            end
         end

         // Pointers, crossings, output register and flags
         always @(posedge clk_i) begin
            if (rst_i | mrst_act[c]) begin
               wptr_ff <= {PW{1'h0}};
               rptr_ff <= {PW{1'h0}};
               wsync1_ff <= {PW{1'h0}};
               wsync2_ff <= {PW{1'h0}};
               rsync1_ff <= {PW{1'h0}};
               rsync2_ff <= {PW{1'h0}};
               out_ff <= {DW{1'h0}};
               ov_ff <= 1'h0;
               fetch_ff <= 1'h0;
               space_ff <= 1'h0;
               avail_ff <= 1'h0;
               full_n_ff <= 1'h0;
               iready_ff <= 1'h0;
               empty_n_ff <= 1'h0;
               oready_ff <= 1'h0;
               ae_n_ff <= 1'h0;
               af_n_ff <= 1'h1;
               hold_ff <= 3'h0;
            end else begin
               if (wr_ok) begin
                  wptr_ff <= wptr_ff + {{(PW-1){1'h0}}, 1'h1};
               end
               // Replay rewinds reads to the reset position
               if (replay_act[c]) begin // R21
                  rptr_ff <= {PW{1'h0}};
               end else if (fetch) begin
                  rptr_ff <= rptr_ff + {{(PW-1){1'h0}}, 1'h1};
               end
               // Write pointer into the read port's timing
               if (rd_edge[c]) begin
                  wsync1_ff <= wptr_ff; // R25
                  wsync2_ff <= wsync1_ff; // R25
               end
               // Read pointer into the write port's timing
               if (wr_edge[c]) begin
                  rsync1_ff <= rptr_ff; // R25
                  rsync2_ff <= rsync1_ff; // R25
               end
               // Memory data lands one cycle after the fetch
               fetch_ff <= fetch;
               if (fetch_ff) begin
                  out_ff <= mem_q; // R7 R8
                  ov_ff <= 1'h1;
               end else if (rd_take & fall_through_select_s & ~fetch) begin
                  ov_ff <= 1'h0;
               end
               // Recovery count restarts while replay is held
               if (replay_act[c]) begin
                  hold_ff <= HOLD_MAX;
               end else if (hold_ff != 3'h0) begin
                  hold_ff <= hold_ff - 3'h1;
               end
               // Empty and full settle once recovery is over
               if (hold_ff <= `BSFC_NEAR_HOLD) begin // R18
                  space_ff <= wcount < `BSFC_DEPTH; // R11 R12
                  avail_ff <= rcount != {PW{1'h0}}; // R9 R10
               end
               // Near flags wait two more cycles
               if (hold_ff == 3'h0) begin // R19
                  ae_n_ff <= rcount > {1'h0, ne_ff}; // R13
                  af_n_ff <= nf_sum < {1'h0, `BSFC_DEPTH}; // R14 R15
               end
               // Mode decides which flag pair is live
               full_n_ff <= ~fall_through_select_s & space_ff; // R23 R11 R12
               iready_ff <= fall_through_select_s & space_ff; // R23 R11 R12
               empty_n_ff <= ~fall_through_select_s & avail_ff; // R23 R9 R10
               oready_ff <= fall_through_select_s & ov_ff; // R23 R7 R8
            end
         end

         assign space_w[c] = space_ff;
         assign prog_w[c] = prog_ff;
         assign full_n_w[c] = full_n_ff;
         assign iready_w[c] = iready_ff;
         assign empty_n_w[c] = empty_n_ff;
         assign oready_w[c] = oready_ff;
         assign ae_n_w[c] = ae_n_ff;
         assign af_n_w[c] = af_n_ff;
         assign out_w[c*DW +: DW] = out_ff;
      end
   endgenerate

   // ****************************************************
   // Output pins
   // ****************************************************
   // Forward reads come out right, reverse reads left
   assign right_data_o = out_w[DW-1:0];
   assign left_data_o = out_w[2*DW-1:DW];
   assign left_data_oe_o = l_oe_ff;
   assign right_data_oe_o = r_oe_ff;
   // Write side flags of each FIFO
   assign left_full_n_o = full_n_w[0];
   assign left_input_ready_o = iready_w[0];
   assign right_full_n_o = full_n_w[1];
   assign right_input_ready_o = iready_w[1];
   // Read side flags of each FIFO
   assign right_empty_n_o = empty_n_w[0];
   assign right_output_ready_o = oready_w[0];
   assign left_empty_n_o = empty_n_w[1];
   assign left_output_ready_o = oready_w[1];
   // Near flags; reverse pair faces left empty, right full
   assign right_almost_empty_n_o = ae_n_w[0];
   assign left_almost_full_n_o = af_n_w[0];
   assign left_almost_empty_n_o = ae_n_w[1]; // R24
   assign right_almost_full_n_o = af_n_w[1]; // R24
endmodule // bsfc_top

// File: include/bsfc_consts.vh
`ifndef BSFC_CONSTS_VH
`define BSFC_CONSTS_VH
// Contract
// (R1) Parallel offset load only while left full high
// (R2) Offset writes may be spaced by idle cycles
// (R3) Forward write: select low, direction high, mail low
// (R4) Forward read: select low, direction high, mail low
// (R5) Reverse write: select low, direction low, mail low
// (R6) Reverse read: select low, direction low, mail low
// (R7) Fall-through forward word reaches right register fast
// (R8) Fall-through reverse word reaches left register fast
// (R9) Standard mode right empty flag rises after write
// (R10) Standard mode left empty flag rises after write
// (R11) Left full or ready rises after right read
// (R12) Right full or ready rises after left read
// (R13) Near-empty flag releases once above its offset
// (R14) Near-full flag releases once below its threshold
// (R15) Near-full threshold counts from the built depth
// (R16) Writer stays idle around and during replay
// (R17) Replay only in standard mode, clocks running
// (R18) Empty and full valid after replay recovery
// (R19) Near flags updated two cycles after recovery
// (R20) Writer keeps word count below depth minus two
// (R21) Reverse FIFO replays through its own request
// (R22) Reset may preset both offsets to eight
// (R23) Mode picks flag meaning; output word uncounted
// (R24) Reverse offsets drive left near-empty, right near-full
// (R25) Pointers cross through sync stages before compare

// Word width and memory geometry (1K build)
`define BSFC_DW 36
`define BSFC_AW 10
`define BSFC_PW 11
`define BSFC_DEPTH 11'h400
// Offset field sits in the low data bits
`define BSFC_OFF_LSB 0
// Offset value after a master reset
`define BSFC_OFF_RST 10'h008
// Clock period and replay recovery time in ns
`define BSFC_CLK_NS 40
`define BSFC_REPLAY_NS 90
// Recovery time as whole clock cycles, rounded up
`define BSFC_RECOV_CYC ((`BSFC_REPLAY_NS+`BSFC_CLK_NS-1)/`BSFC_CLK_NS)
// Extra cycles before near flags update after replay
`define BSFC_NEAR_HOLD 3'h2
`endif

// File: verilog/bsfc_sync3.v
`timescale 1ns/1ns
// ****************************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************************
module bsfc_sync3 #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'h0}}
) (
   input wire clk_i,
   input wire rst_i,
   input wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);
   reg [W-1:0] s1_ff; // First stage, read by s2 only
   reg [W-1:0] s2_ff; // Second stage
   reg [W-1:0] s3_ff; // Third stage
   reg [W-1:0] out_ff; // Filtered level
   // Shift; set a bit once stages two and three are both high, clear it once they differ
   always @(posedge clk_i) begin
      if (rst_i) begin
         s1_ff <= INIT;
         s2_ff <= INIT;
         s3_ff <= INIT;
         out_ff <= INIT;
      end else begin
         s1_ff <= async_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         out_ff <= (s2_ff & s3_ff) | (out_ff & ~(s2_ff ^ s3_ff));
      end
   end
   assign sync_o = out_ff;
endmodule // bsfc_sync3

// File: verilog/bsfc_mem.v
`timescale 1ns/1ns
// ****************************************************
// Simple dual-port word store, registered read
// ****************************************************
module bsfc_mem #(
   parameter DW = 36,
   parameter AW = 10
) (
   input wire clk_i,
   input wire rst_i,
   input wire wr_en_i,
   input wire [AW-1:0] wr_addr_i,
   input wire [DW-1:0] wr_data_i,
   input wire [AW-1:0] rd_addr_i,
   output wire [DW-1:0] rd_data_o
);
   reg [DW-1:0] mem_ff [0:(1<<AW)-1]; // Storage array
   reg [DW-1:0] q_ff; // Read data register
   // Write port, no reset on the array
   always @(posedge clk_i) begin
      if (wr_en_i) begin
         mem_ff[wr_addr_i] <= wr_data_i;
      end
   end
   // Read port, one cycle latency
   always @(posedge clk_i) begin
      if (rst_i) begin
         q_ff <= {DW{1'h0}};
      end else begin
         q_ff <= mem_ff[rd_addr_i];
      end
   end
   assign rd_data_o = q_ff;
endmodule // bsfc_mem

// File: bench/bsfc_top_monitor.sv
`timescale 1ns/1ns
// ****************************
// Flag checker at top ports
// ****************************
module bsfc_top_monitor (
   input logic clk_i,
   input logic rst_i,
   input logic fall_through_select_i,
   input logic fwd_master_reset_n_i,
   input logic rev_master_reset_n_i,
   input logic left_chip_select_n_i,
   input logic left_direction_i,
   input logic right_chip_select_n_i,
   input logic right_direction_i,
   input logic [35:0] right_data_o,
   input logic left_data_oe_o,
   input logic right_data_oe_o,
   input logic left_full_n_o,
   input logic left_input_ready_o,
   input logic right_full_n_o,
   input logic right_input_ready_o,
   input logic left_empty_n_o,
   input logic right_empty_n_o,
   input logic right_output_ready_o,
   input logic left_almost_empty_n_o,
   input logic right_almost_empty_n_o,
   input logic left_almost_full_n_o,
   input logic right_almost_full_n_o
);
   default clocking dcb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Unused flag pins stay low in each mode
   a_std_ready_low: assert property (
      (!fall_through_select_i)[*8] |->
      !left_input_ready_o && !right_input_ready_o)
      else $error("ready flag high in standard mode");
   a_fall_through_select_std_low: assert property (
      fall_through_select_i[*8] |->
      !left_full_n_o && !right_full_n_o && !right_empty_n_o)
      else $error("standard flag high in fall-through mode");
   // Held master reset clears the flags of its FIFO
   a_fwd_reset_flags: assert property (
      (!fwd_master_reset_n_i)[*8] |-> !left_full_n_o &&
      !right_empty_n_o && !right_almost_empty_n_o && left_almost_full_n_o)
      else $error("forward flags wrong in reset");
   a_rev_reset_flags: assert property (
      (!rev_master_reset_n_i)[*8] |-> !right_full_n_o &&
      !left_empty_n_o && !left_almost_empty_n_o && right_almost_full_n_o)
      else $error("reverse flags wrong in reset");
   // Bus drive follows a held read select
   a_left_drive: assert property (
      (!left_chip_select_n_i && !left_direction_i)[*4] |->
      ##[0:4] left_data_oe_o)
      else $error("left bus not driven on read");
   a_right_drive: assert property (
      (!right_chip_select_n_i && right_direction_i)[*4] |->
      ##[0:4] right_data_oe_o)
      else $error("right bus not driven on read");
   // Word is in place when ready rises
   a_word_held: assert property (
      $rose(right_output_ready_o) |=> $stable(right_data_o)[*3])
      else $error("right word moved after ready rose");
   // Near-empty release means a word is readable soon
   a_near_empty_words: assert property (
      $rose(right_almost_empty_n_o) |->
      ##[0:4] (right_empty_n_o || right_output_ready_o))
      else $error("near-empty released with no word");
endmodule // bsfc_top_monitor
bind bsfc_top bsfc_top_monitor u_mon (.*);

// File: bench/bsfc_port_model.sv
`timescale 1ns/1ns
// ****************************
// Port controller on one side
// ****************************
module bsfc_port_model #(
   parameter [2:0] PH = 3'h0
) (
   input wire clk_i,
   input wire [35:0] data_i,
   output logic port_clk_o,
   output logic cs_n_o,
   output logic dir_o,
   output logic mail_o,
   output logic [35:0] data_o
);
   logic [2:0] cnt_ff = PH; // Phase counter
   initial begin
      cs_n_o = 1'b1;
      dir_o = 1'b0;
      mail_o = 1'b0;
      data_o = 36'h000000000;
   end
   // Free-running port clock, eight system clocks a period
   always @(posedge clk_i) begin
      cnt_ff <= cnt_ff + 3'h1;
   end
   assign port_clk_o = cnt_ff[2];
   // One access: set up while low, release after the taken edge
   task acc(input logic dir, input logic [35:0] d,
            output logic [35:0] q);
      @(negedge port_clk_o);
      cs_n_o <= 1'b0;
      dir_o <= dir;
      mail_o <= 1'b0;
      data_o <= d;
      @(negedge port_clk_o);
      cs_n_o <= 1'b1;
      data_o <= ~d;
      @(posedge port_clk_o);
      q = data_i;
   endtask
endmodule // bsfc_port_model

// File: bench/bsfc_top_tb.sv
`timescale 1ns/1ns
// ****************************
// Bench for the two-way FIFO flags
// ****************************
module bsfc_top_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fmr_n = 1'b1;
   logic rmr_n = 1'b1;
   logic frp_n = 1'b1;
   logic rrp_n = 1'b1;
   logic ft_sel = 1'b0;
   logic prog_sel = 1'b0;
   int num_errors = 0;
   int n_compared = 0;
   wire lpc, lcs_n, ldir, lmb, rpc, rcs_n, rdir, rmb;
   wire [35:0] ldi, rdi, ldat, rdat;
   wire loe, roe, lf_n, lir, rf_n, rir, le_n, lor, re_n, ror;
   wire lae_n, rae_n, laf_n, raf_n;
   always #20 clk = ~clk;
   bsfc_top DUT (.clk_i(clk), .rst_i(rst),
      .left_port_clock_i(lpc), .left_chip_select_n_i(lcs_n),
      .left_direction_i(ldir), .left_mail_select_i(lmb),
      .left_data_i(ldi), .left_data_o(ldat), .left_data_oe_o(loe),
      .right_port_clock_i(rpc), .right_chip_select_n_i(rcs_n),
      .right_direction_i(rdir), .right_mail_select_i(rmb),
      .right_data_i(rdi), .right_data_o(rdat), .right_data_oe_o(roe),
      .fwd_master_reset_n_i(fmr_n), .rev_master_reset_n_i(rmr_n),
      .fwd_replay_n_i(frp_n), .rev_replay_n_i(rrp_n),
      .fall_through_select_i(ft_sel), .offset_program_select_i(prog_sel),
      .left_full_n_o(lf_n), .left_input_ready_o(lir),
      .right_full_n_o(rf_n), .right_input_ready_o(rir),
      .left_empty_n_o(le_n), .left_output_ready_o(lor),
      .right_empty_n_o(re_n), .right_output_ready_o(ror),
      .left_almost_empty_n_o(lae_n), .right_almost_empty_n_o(rae_n),
      .left_almost_full_n_o(laf_n), .right_almost_full_n_o(raf_n));
   bsfc_port_model #(.PH(3'h0)) u_left (.clk_i(clk), .data_i(ldat),
      .port_clk_o(lpc), .cs_n_o(lcs_n), .dir_o(ldir), .mail_o(lmb),
      .data_o(ldi));
   bsfc_port_model #(.PH(3'h3)) u_right (.clk_i(clk), .data_i(rdat),
      .port_clk_o(rpc), .cs_n_o(rcs_n), .dir_o(rdir), .mail_o(rmb),
      .data_o(rdi));
   // ****************************
   // Compare, access and verdict helpers
   // ****************************
   task chk_bit(input logic got, input logic exp);
      chk_word({35'h0, got}, {35'h0, exp});
   endtask
   task chk_word(input logic [35:0] got, input logic [35:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function logic [35:0] pat(input int i);
      pat = {4'hA, i[31:0]};
   endfunction
   task wr(input logic fwd, input logic [35:0] d);
      logic [35:0] q;
      if (fwd) u_left.acc(1'b1, d, q);
      else u_right.acc(1'b0, d, q);
   endtask
   task rd(input logic fwd, output logic [35:0] q);
      if (fwd) u_right.acc(1'b1, 36'h000000000, q);
      else u_left.acc(1'b0, 36'h000000000, q);
   endtask
   task wr_n(input logic fwd, input int a, input int b);
      for (int i = a; i < b; i++) wr(fwd, pat(i));
   endtask
   task rd_n(input logic fwd, input int a, input int b);
      logic [35:0] q;
      for (int i = a; i < b; i++) begin
         rd(fwd, q);
         chk_word(q, pat(i));
      end
   endtask
   // Flag latency: two port edges plus a few system clocks
   task settle;
      repeat (24) @(posedge clk);
   endtask
   task mreset(input logic ft, input logic pg);
      ft_sel <= ft;
      prog_sel <= pg;
      fmr_n <= 1'b0;
      rmr_n <= 1'b0;
      repeat (8) @(posedge clk);
      fmr_n <= 1'b1;
      rmr_n <= 1'b1;
      repeat (12) @(posedge clk);
   endtask
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ****************************
   // Scenarios
   // ****************************
   task t_fill;
      mreset(1'b0, 1'b0);
      chk_bit(lf_n, 1'b1);
      chk_bit(laf_n, 1'b1);
      wr_n(1'b1, 0, 8);
      settle;
      chk_bit(rae_n, 1'b0);
      wr_n(1'b1, 8, 9);
      settle;
      chk_bit(rae_n, 1'b1);
      chk_bit(re_n, 1'b1);
      wr_n(1'b1, 9, 1015);
      settle;
      chk_bit(laf_n, 1'b1);
      wr_n(1'b1, 1015, 1016);
      settle;
      chk_bit(laf_n, 1'b0);
      wr_n(1'b1, 1016, 1025);
      settle;
      chk_bit(lf_n, 1'b0);
      rd_n(1'b1, 0, 1);
      settle;
      chk_bit(lf_n, 1'b1);
      rd_n(1'b1, 1, 9);
      settle;
      chk_bit(laf_n, 1'b1);
      rd_n(1'b1, 9, 1024);
      settle;
      chk_bit(re_n, 1'b0);
      $display("fill test done");
   endtask
   task t_rev;
      mreset(1'b0, 1'b0);
      wr(1'b0, pat(5));
      settle;
      chk_bit(le_n, 1'b1);
      chk_bit(lae_n, 1'b0);
      chk_bit(rf_n, 1'b1);
      chk_bit(raf_n, 1'b1);
      rd_n(1'b0, 5, 6);
      settle;
      chk_bit(le_n, 1'b0);
      $display("reverse test done");
   endtask
   task t_fall_through_select;
      logic [35:0] q;
      mreset(1'b1, 1'b0);
      chk_bit(lir, 1'b1);
      chk_bit(lf_n, 1'b0);
      chk_bit(rir, 1'b1);
      wr(1'b1, pat(1));
      wr(1'b0, pat(2));
      settle;
      chk_bit(ror, 1'b1);
      chk_word(rdat, pat(1));
      chk_bit(lor, 1'b1);
      chk_word(ldat, pat(2));
      rd(1'b1, q);
      chk_word(q, pat(1));
      settle;
      chk_bit(ror, 1'b0);
      $display("fall-through test done");
   endtask
   task t_prog;
      mreset(1'b0, 1'b1);
      chk_bit(lf_n, 1'b1);
      wr(1'b1, 36'h000000002);
      repeat (40) @(posedge clk);
      wr(1'b1, 36'h000000004);
      repeat (40) @(posedge clk);
      wr(1'b1, 36'h000000001);
      wr(1'b1, 36'h000000002);
      wr_n(1'b1, 0, 2);
      wr_n(1'b0, 0, 1);
      settle;
      chk_bit(rae_n, 1'b0);
      chk_bit(lae_n, 1'b0);
      wr_n(1'b1, 2, 3);
      wr_n(1'b0, 1, 2);
      settle;
      chk_bit(rae_n, 1'b1);
      chk_bit(lae_n, 1'b1);
      $display("offset test done");
   endtask
   task t_replay(input logic fwd);
      mreset(1'b0, 1'b0);
      wr_n(fwd, 0, 10);
      rd_n(fwd, 0, 5);
      settle;
      chk_bit(fwd ? rae_n : lae_n, 1'b0);
      // Writer stays idle through the request and recovery
      if (fwd) frp_n <= 1'b0;
      else rrp_n <= 1'b0;
      repeat (16) @(posedge clk);
      frp_n <= 1'b1;
      rrp_n <= 1'b1;
      settle;
      chk_bit(fwd ? re_n : le_n, 1'b1);
      chk_bit(fwd ? rae_n : lae_n, 1'b1);
      rd_n(fwd, 0, 10);
      $display("replay test done");
   endtask
   // Watchdog sized well past the expected run
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      test_done;
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_fill;
      t_rev;
      t_fall_through_select;
      t_prog;
      t_replay(1'b1);
      t_replay(1'b0);
      test_done;
   end
endmodule // bsfc_top_tb
